/* File: rtl/diev_top.sv */
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - Four built-in plus four expansion inputs
// - Expansion numbering follows connection order
// - Pulse mode: one edge per pulse
// - Transition mode: both edges are events
// - Normal open-to-closed, inverting closed-to-open
// - Transition mode ignores polarity
// - Level accepted after stable debounce time
// - Debounce time shared by input pairs
// - Per-input fault link enable, default off
// - Linked closing raises global external trigger
// - Recording starts only if enable set
// - Simultaneous linked inputs trigger only once
// - Lockout until all linked inputs open
// - Trigger also goes to setpoint logic
module diev_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] di_builtin,
  input wire logic [3:0] di_expansion,
  output logic [7:0] di_event,
  output logic [7:0] di_level,
  output logic fr_start,
  output logic setpoint_ext_evt,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  diev_pkg::diev_cfg_s cfg_q;
  diev_pkg::diev_trig_s trig;
  logic [diev_pkg::DBW-1:0] db_q [diev_pkg::NUM_PAIR];
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic lock_q;
  logic [diev_pkg::IRQ_W-1:0] ist_q, ien_q;
  logic [7:0] evt_q, lvl_q;
  logic fr_q, sp_q;
  logic [7:0] ch_evt, ch_lvl, ch_rise;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic aw_v_q, w_v_q;
  diev_pkg::diev_wr_e wst_q;
  logic [1:0] bresp_q;
  logic rv_q;
  logic [31:0] rd_q;
  logic [1:0] rresp_q;

  // Built-ins occupy 1-4; expansion pins are wired in connection order
  wire [7:0] pins = {di_expansion, di_builtin};

  // Millisecond enable pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_cnt_q == 16'(diev_pkg::TICK_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == 16'(diev_pkg::TICK_CYC - 1)) ? '0 : tick_cnt_q + 16'h0001;
    end
  end

  for (genvar i = 0; i < diev_pkg::NUM_IN; i++) begin : g_ch
    diev_chan u_ch (
      .mclk(mclk),
      .rst_b(rst_b),
      .pin(pins[i]),
      .tick(tick_q),
      .db_ms(db_q[i/2]),
      .transition_pulse_mode(cfg_q.mode[i]),
      .inv(cfg_q.pol[i]),
      .level(ch_lvl[i]),
      .rise(ch_rise[i]),
      .evt(ch_evt[i])
    );
  end

  // Fault trigger: one pulse however many linked inputs close at once
  wire [7:0] linked_rise = ch_rise & cfg_q.link;
  wire any_linked_closed = |(ch_lvl & cfg_q.link);
  assign trig.ext_trig = |linked_rise && !lock_q;
  assign trig.fr_start = trig.ext_trig && cfg_q.fr_ext_en;
  assign trig.setpoint_evt = trig.ext_trig;
  assign trig.lockout = lock_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= 1'b0;
    end else if (trig.ext_trig) begin
      lock_q <= 1'b1;
    end else if (!any_linked_closed && linked_rise == 8'h00) begin
      lock_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      evt_q <= '0;
      lvl_q <= '0;
      fr_q <= 1'b0;
      sp_q <= 1'b0;
    end else begin
      evt_q <= ch_evt;
      lvl_q <= ch_lvl;
      fr_q <= trig.fr_start;
      sp_q <= trig.setpoint_evt;
    end
  end
  assign di_event = evt_q;
  assign di_level = lvl_q;
  assign fr_start = fr_q;
  assign setpoint_ext_evt = sp_q;

  // Interrupts: per-input event bits plus the external trigger
  wire [diev_pkg::IRQ_W-1:0] irq_set = {trig.ext_trig, ch_evt};
  wire wr_go = aw_v_q && w_v_q && wst_q == diev_pkg::WR_IDLE;
  wire wr_map = aw_q <= diev_pkg::OFS_IRQ_CLR;
  wire clr_hit = wr_go && aw_q == diev_pkg::OFS_IRQ_CLR;
  wire [diev_pkg::IRQ_W-1:0] irq_clr = clr_hit ? wd_q[diev_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(ist_q & ien_q);

  // AXI4-Lite write: address and data latched independently
  assign s_axi_awready = !aw_v_q;
  assign s_axi_wready = !w_v_q;
  assign s_axi_bvalid = wst_q == diev_pkg::WR_RESP;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aw_q <= '0;
      aw_v_q <= 1'b0;
      wd_q <= '0;
      ws_q <= '0;
      w_v_q <= 1'b0;
      wst_q <= diev_pkg::WR_IDLE;
      bresp_q <= diev_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_v_q) begin
        aw_q <= {s_axi_awaddr[7:2], 2'b00};
        aw_v_q <= 1'b1;
      end
      if (s_axi_wvalid && !w_v_q) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_v_q <= 1'b1;
      end
      case (wst_q)
        diev_pkg::WR_IDLE: begin
          if (wr_go) begin
            wst_q <= diev_pkg::WR_RESP;
            bresp_q <= wr_map ? diev_pkg::RESP_OKAY : diev_pkg::RESP_SLVERR;
          end
        end
        diev_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wst_q <= diev_pkg::WR_IDLE;
            aw_v_q <= 1'b0;
            w_v_q <= 1'b0;
          end
        end
        default: wst_q <= diev_pkg::WR_IDLE;
      endcase
    end
  end

  wire b0 = ws_q[0];
  // Debounce write: value in [9:0], pair index in [17:16]
  wire [1:0] db_sel = wd_q[diev_pkg::DB_SEL_LSB +: 2];
  wire [diev_pkg::DBW-1:0] db_raw = wd_q[diev_pkg::DBW-1:0];
  wire [diev_pkg::DBW-1:0] db_new = (db_raw < diev_pkg::DB_MIN_MS) ? diev_pkg::DB_MIN_MS :
                                    (db_raw > diev_pkg::DB_MAX_MS) ? diev_pkg::DB_MAX_MS : db_raw;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= '{mode: diev_pkg::MODE_RST, pol: diev_pkg::POL_RST,
                 link: diev_pkg::LINK_RST, fr_ext_en: diev_pkg::CTRL_RST};
      ien_q <= '0;
      for (int p = 0; p < diev_pkg::NUM_PAIR; p++) begin
        db_q[p] <= diev_pkg::DB_RST_MS;
      end
    end else if (wr_go && b0) begin
      case (aw_q)
        diev_pkg::OFS_MODE: cfg_q.mode <= wd_q[7:0];
        diev_pkg::OFS_POL: cfg_q.pol <= wd_q[7:0];
        diev_pkg::OFS_LINK: cfg_q.link <= wd_q[7:0];
        diev_pkg::OFS_CTRL: cfg_q.fr_ext_en <= wd_q[diev_pkg::CTRL_FR_EXT_EN];
        diev_pkg::OFS_DB: db_q[db_sel] <= db_new;
        diev_pkg::OFS_IRQ_EN: ien_q <= wd_q[diev_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // AXI4-Lite read
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire r_map = ra <= diev_pkg::OFS_EVT && ra != diev_pkg::OFS_IRQ_CLR;
  logic [31:0] r_mux;
  always_comb begin
    r_mux = '0;
    case (ra)
      diev_pkg::OFS_MODE: r_mux = {24'h000000, cfg_q.mode};
      diev_pkg::OFS_POL: r_mux = {24'h000000, cfg_q.pol};
      diev_pkg::OFS_LINK: r_mux = {24'h000000, cfg_q.link};
      diev_pkg::OFS_CTRL: r_mux = {30'h00000000, lock_q, cfg_q.fr_ext_en};
      diev_pkg::OFS_DB: r_mux = {db_q[3][7:0], db_q[2][7:0], db_q[1][7:0], db_q[0][7:0]};
      diev_pkg::OFS_LEVEL: r_mux = {24'h000000, lvl_q};
      diev_pkg::OFS_IRQ_ST: r_mux = {23'h000000, ist_q};
      diev_pkg::OFS_IRQ_EN: r_mux = {23'h000000, ien_q};
      diev_pkg::OFS_EVT: r_mux = {db_q[1][9:8], db_q[0][9:8], 28'h0000000};
      default: r_mux = '0;
    endcase
  end

  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rresp_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rv_q <= 1'b0;
      rd_q <= '0;
      rresp_q <= diev_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rv_q) begin
      rv_q <= 1'b1;
      rd_q <= r_mux;
      rresp_q <= r_map ? diev_pkg::RESP_OKAY : diev_pkg::RESP_SLVERR;
    end else if (rv_q && s_axi_rready) begin
      rv_q <= 1'b0;
    end
  end

  chk_trig_once : assert property (@(posedge mclk) disable iff (!rst_b)
    trig.ext_trig |=> !trig.ext_trig)
    else $error("external trigger raised twice in a row");
  chk_lock_hold : assert property (@(posedge mclk) disable iff (!rst_b)
    lock_q && any_linked_closed |=> lock_q)
    else $error("lockout released while a linked input is closed");
  chk_lock_block : assert property (@(posedge mclk) disable iff (!rst_b)
    lock_q |-> !trig.ext_trig)
    else $error("trigger raised during lockout");
  chk_fr_gate : assert property (@(posedge mclk) disable iff (!rst_b)
    fr_q |-> $past(cfg_q.fr_ext_en) && sp_q)
    else $error("recording started with external trigger disabled");
  chk_trig_link : assert property (@(posedge mclk) disable iff (!rst_b)
    trig.ext_trig |-> |(ch_rise & cfg_q.link))
    else $error("trigger without a linked closing edge");
  chk_sp_copy : assert property (@(posedge mclk) disable iff (!rst_b)
    trig.ext_trig |=> sp_q)
    else $error("setpoint event missing after trigger");
  chk_tick_rate : assert property (@(posedge mclk) disable iff (!rst_b)
    tick_q |=> !tick_q [*8])
    else $error("millisecond tick too frequent");
  chk_db_pair : assert property (@(posedge mclk) disable iff (!rst_b)
    wr_go && b0 && aw_q == diev_pkg::OFS_DB |=> db_q[$past(db_sel)] == $past(db_new))
    else $error("pair debounce write lost");
endmodule : diev_top

/* File: pkg/diev_pkg.sv */
package diev_pkg;

  localparam int unsigned NUM_IN = 8;
  localparam int unsigned NUM_BUILTIN = 4;
  localparam int unsigned NUM_PAIR = NUM_IN / 2;

  // Time base
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DBW = 10;
  localparam logic [DBW-1:0] DB_MIN_MS = 10'h001;
  localparam logic [DBW-1:0] DB_MAX_MS = 10'h3E8;
  localparam logic [DBW-1:0] DB_RST_MS = 10'h00A;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_POL = 8'h04;
  localparam logic [7:0] OFS_LINK = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_DB = 8'h10;
  localparam logic [7:0] OFS_LEVEL = 8'h14;
  localparam logic [7:0] OFS_IRQ_ST = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
  localparam logic [7:0] OFS_EVT = 8'h24;

  // Field positions
  localparam int unsigned CTRL_FR_EXT_EN = 0;
  localparam int unsigned DB_SEL_LSB = 16;
  localparam int unsigned IRQ_TRIG_BIT = 8;
  localparam int unsigned IRQ_W = 9;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] LINK_RST = 8'h00;
  localparam logic CTRL_RST = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] pol;
    logic [7:0] link;
    logic fr_ext_en;
  } diev_cfg_s;

  typedef struct packed {
    logic ext_trig;
    logic fr_start;
    logic setpoint_evt;
    logic lockout;
  } diev_trig_s;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } diev_wr_e;

endpackage : diev_pkg

/* File: rtl/diev_chan.sv */
`timescale 1ns/1ps
module diev_chan (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pin,
  input wire logic tick,
  input wire logic [diev_pkg::DBW-1:0] db_ms,
  input wire logic transition_pulse_mode,
  input wire logic inv,
  output logic level,
  output logic rise,
  output logic evt
);
  logic s1_q, s2_q;
  logic level_q;
  logic [diev_pkg::DBW-1:0] cnt_q;
  wire differ = s2_q != level_q;
  wire done = differ && tick && (cnt_q + 10'h001 >= db_ms);
  wire fall = done && level_q;
  assign rise = done && !level_q;
  assign level = level_q;
  // Mode picks edges; polarity is moot in transition mode
  assign evt = transition_pulse_mode ? done : (inv ? fall : rise);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else if (!differ) begin
      cnt_q <= '0;
    end else if (done) begin
      level_q <= s2_q;
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  chk_db_hold : assert property (@(posedge mclk) disable iff (!rst_b)
    $changed(level_q) |-> $past(differ) && $past(tick))
    else $error("level changed without a debounce expiry");
  chk_evt_pol : assert property (@(posedge mclk) disable iff (!rst_b)
    evt && !transition_pulse_mode |-> rise == !inv)
    else $error("single edge event on wrong edge");
endmodule : diev_chan

/* File: bench/diev_contacts.sv */
`timescale 1ns/1ps
module diev_contacts (
  input wire logic mclk,
  input wire logic [7:0] want,
  input wire logic [3:0] bounce,
  output logic [3:0] di_builtin,
  output logic [3:0] di_expansion
);
  logic [7:0] cur_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  // Chatter flips steady contacts too, so short glitches must be filtered
  always @(posedge mclk) begin
    if (want !== last_q) begin
      last_q <= want;
      cnt_q <= bounce;
      cur_q <= ~want;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      cur_q <= cnt_q[0] ? want : ~want;
    end else begin
      cur_q <= want;
    end
  end
  assign di_builtin = cur_q[3:0];
  assign di_expansion = cur_q[7:4];
endmodule : diev_contacts

/* File: bench/diev_top_test.sv */
`timescale 1ns/1ps
module diev_top_test;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] want = 8'h00;
  logic [3:0] bounce = 4'h0;
  logic [3:0] di_builtin, di_expansion, s_axi_wstrb = 4'hF;
  logic [7:0] di_event, di_level, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic fr_start, setpoint_ext_evt, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] mode, pol, p1, ev;
  int err_total = 0;
  int compares = 0;
  int frc = 0;
  int spc = 0;
  int evc [8];
  initial forever #12.5 mclk = ~mclk;
  diev_contacts diev_contacts_inst (.mclk, .want, .bounce, .di_builtin, .di_expansion);
  diev_top diev_top_inst (.mclk, .rst_b, .di_builtin, .di_expansion, .di_event, .di_level,
    .fr_start, .setpoint_ext_evt, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always @(posedge mclk) begin
    for (int i = 0; i < 8; i++) if (di_event[i] === 1'h1) evc[i]++;
    if (fr_start === 1'h1) frc++;
    if (setpoint_ext_evt === 1'h1) spc++;
  end
  task automatic finish_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo;
    err_total++;
    $display("ERROR t=%0t wait limit got=%h exp=%h", $time, 1'h0, 1'h1);
    finish_test();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_d, w_d;
    aw_d = 1'h0;
    w_d = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (!aw_d && s_axi_awready === 1'h1) begin
        aw_d = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_d && s_axi_wready === 1'h1) begin
        w_d = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
      if (s_axi_bvalid === 1'h1) break;
    end
    rs = s_axi_bresp;
    if (n == 50) tmo();
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    if (n == 50) tmo();
  endtask : rdr
  // Debounced level changes only at a millisecond tick, so the bound spans two ticks
  task automatic settle(input logic [7:0] exp);
    int n;
    for (n = 0; n < 90000; n++) begin
      @(posedge mclk);
      if (di_level === exp) break;
    end
    repeat (4) @(posedge mclk);
    if (n == 90000) tmo();
    chk(di_level, exp);
  endtask : settle
  task automatic chkev(input logic [7:0] exp);
    for (int i = 0; i < 8; i++) begin
      chk(evc[i], exp[i]);
      evc[i] = 0;
    end
  endtask : chkev
  initial begin
    rd = $urandom(32'hA94B);
    repeat (8) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    chk({13'h0, fr_start, setpoint_ext_evt, irq, di_event, di_level}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rdr(8'(4 * i));
      chk(rd, (i == 4) ? 32'h0A0A0A0A : 32'h0);
    end
    rdr(8'h30);
    chk({30'h0, rs}, {30'h0, diev_pkg::RESP_SLVERR});
    chk(rd, 32'h0);
    wr(8'h40, 32'h0);
    chk(rs, diev_pkg::RESP_SLVERR);
    $display("test reset done");
    mode = 8'($urandom);
    pol = 8'($urandom);
    for (int p = 0; p < 4; p++) wr(diev_pkg::OFS_DB, 32'(p) << 16 | 32'h1);
    rdr(diev_pkg::OFS_DB);
    chk(rd, 32'h01010101);
    wr(diev_pkg::OFS_MODE, {24'h0, mode});
    wr(diev_pkg::OFS_POL, {24'h0, pol});
    wr(diev_pkg::OFS_LINK, 32'h0C);
    wr(diev_pkg::OFS_CTRL, 32'h1);
    wr(diev_pkg::OFS_IRQ_EN, 32'h1FF);
    p1 = 8'($urandom) | 8'h0C;
    bounce <= 4'($urandom);
    want <= p1;
    settle(p1);
    ev = (mode | ~pol) & p1;
    chkev(ev);
    chk(frc, 1);
    chk(spc, 1);
    rdr(diev_pkg::OFS_LEVEL);
    chk(rd, {24'h0, p1});
    rdr(diev_pkg::OFS_IRQ_ST);
    chk(rd, {23'h0, 1'h1, ev});
    chk(irq, 1'h1);
    rdr(diev_pkg::OFS_CTRL);
    chk(rd, 32'h3);
    wr(diev_pkg::OFS_IRQ_CLR, 32'h1FF);
    @(posedge mclk);
    chk(irq, 1'h0);
    wr(diev_pkg::OFS_IRQ_EN, 32'h0);
    $display("test closing done");
    want <= 8'h08;
    settle(8'h08);
    chkev((mode | pol) & p1 & 8'hF7);
    chk(frc, 1);
    chk(spc, 1);
    rdr(diev_pkg::OFS_IRQ_ST);
    chk(rd, {24'h0, (mode | pol) & p1 & 8'hF7});
    chk(irq, 1'h0);
    rdr(diev_pkg::OFS_CTRL);
    chk(rd, 32'h3);
    $display("test release done");
    finish_test();
  end
endmodule : diev_top_test
